// *** core/tmo_pkg.sv ***
// Constants, register map and field layout of the timer output level block.
// Assumes a single system clock and a plain strobe register port.
package tmo_pkg;

  localparam int unsigned TMO_AW = 8;
  localparam int unsigned TMO_DW = 16;

  // Register word offsets (byte addresses).
  localparam logic [7:0] TMO_OFS_COUNT  = 8'h00;
  localparam logic [7:0] TMO_OFS_CMP_A  = 8'h04;
  localparam logic [7:0] TMO_OFS_CMP_B  = 8'h08;
  localparam logic [7:0] TMO_OFS_MODE   = 8'h0C;
  localparam logic [7:0] TMO_OFS_OUTCTL = 8'h10;
  localparam logic [7:0] TMO_OFS_IRQST  = 8'h14;
  localparam logic [7:0] TMO_OFS_IRQMSK = 8'h18;

  // Mode control field positions.
  localparam int unsigned TMO_MODE_EDGE_TOG = 1;
  localparam int unsigned TMO_MODE_LO       = 2;
  localparam int unsigned TMO_MODE_HI       = 3;
  localparam int unsigned TMO_MODE_CAPA     = 4;
  localparam int unsigned TMO_MODE_CAPB     = 5;

  // Output control field positions.
  localparam int unsigned TMO_OC_ENABLE    = 0;
  localparam int unsigned TMO_OC_TOG_A     = 1;
  localparam int unsigned TMO_OC_PRE_LOW   = 2;
  localparam int unsigned TMO_OC_PRE_HIGH  = 3;
  localparam int unsigned TMO_OC_TOG_B     = 4;
  localparam int unsigned TMO_OC_OS_EN     = 5;
  localparam int unsigned TMO_OC_OS_TRIG   = 6;
  localparam int unsigned TMO_OC_ROUTE_SHR = 7;

  // Interrupt status and mask bit positions and field width.
  localparam int unsigned TMO_IRQ_A   = 0;
  localparam int unsigned TMO_IRQ_B   = 1;
  localparam int unsigned TMO_IRQ_OVF = 2;
  localparam int unsigned TMO_IRQ_W   = 3;

  // Reset values and the counter's top value.
  localparam logic [5:0]  TMO_MODE_RST   = 6'h00;
  localparam logic [7:0]  TMO_OUTCTL_RST = 8'h00;
  localparam logic [15:0] TMO_CMP_RST    = 16'h0000;
  localparam logic [2:0]  TMO_IRQ_RST    = 3'h0;
  localparam logic [15:0] TMO_COUNT_MAX  = 16'hFFFF;

  // Count clock divider default.
  localparam int unsigned TMO_PRESCALE_DEF = 4;

  typedef enum logic [1:0] {
    TMO_STOP,
    TMO_FREE_RUN,
    TMO_CLR_EDGE_A,
    TMO_CLR_MATCH_A
  } tmo_mode_t;

endpackage : tmo_pkg

// *** core/tmo_timer16.sv ***
// One 16-bit timer channel with output level preset and match toggling.
// Capture pins are asynchronous and are synchronised here; registers are
// reached over a plain strobe port with read data one cycle later.
`timescale 1ns/1ps
module tmo_timer16
  import tmo_pkg::*;
#(
  parameter int          PRESCALE = TMO_PRESCALE_DEF,
  parameter int unsigned CHANNEL  = 0
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic [TMO_AW-1:0] i_addr,
  input  wire logic [TMO_DW-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [TMO_DW-1:0] o_rdata,
  input  wire logic              i_capture_in_a_pin,
  input  wire logic              i_capture_in_b_pin,
  output logic                   o_timer_out_pin,
  output logic                   o_timer_out_ded_oe,
  output logic                   o_timer_out_shr_oe,
  output logic                   o_irq
);

  // Refuse dividers and channel numbers that the logic below cannot serve.
  if (PRESCALE < 2 || PRESCALE > 65536) begin : g_bad_prescale
    $error("PRESCALE must lie between 2 and 65536");
  end
  if (CHANNEL > 3) begin : g_bad_channel
    $error("CHANNEL must lie between 0 and 3");
  end

  localparam int unsigned PSW = $clog2(PRESCALE);
  localparam logic [PSW-1:0] PS_LAST = PSW'(PRESCALE - 1);
  localparam logic           OS_SHR_OK = (CHANNEL < 2);

  logic [TMO_DW-1:0]    count_q;
  logic [TMO_DW-1:0]    cmp_a_q;
  logic [TMO_DW-1:0]    cmp_b_q;
  logic [5:0]           mode_ctl_q;
  logic [7:0]           out_ctl_q;
  logic [TMO_IRQ_W-1:0] irq_st_q;
  logic [TMO_IRQ_W-1:0] irq_msk_q;
  logic [PSW-1:0]       ps_q;
  logic                 tick_q;
  logic                 out_q;
  logic                 os_active_q;
  logic [2:0]           sync_a_q;
  logic [2:0]           sync_b_q;

  tmo_mode_t mode;
  logic      running;
  logic      route_shr;
  logic      wr_mode;
  logic      wr_outctl;
  logic      edge_a;
  logic      edge_b;
  logic      match_a;
  logic      match_b;
  logic      cap_a_mode;
  logic      cap_b_mode;
  logic      cap_into_a;
  logic      cap_into_b;
  logic      ev_a;
  logic      ev_b;
  logic      ovf;
  logic      os_start;
  logic      tog_match_a;
  logic      tog_match_b;
  logic      tog_edge;
  logic      os_allowed;

  assign mode       = tmo_mode_t'(mode_ctl_q[TMO_MODE_HI:TMO_MODE_LO]);
  assign running    = (mode != TMO_STOP);
  assign route_shr  = out_ctl_q[TMO_OC_ROUTE_SHR];
  assign wr_mode    = i_wr && (i_addr == TMO_OFS_MODE);
  assign wr_outctl  = i_wr && (i_addr == TMO_OFS_OUTCTL);
  assign cap_a_mode = mode_ctl_q[TMO_MODE_CAPA];
  assign cap_b_mode = mode_ctl_q[TMO_MODE_CAPB];

  // Input a is lost to the output when the output sits on the shared pin.
  assign edge_a = running && !route_shr && sync_a_q[1] && !sync_a_q[2];
  assign edge_b = running && sync_b_q[1] && !sync_b_q[2];

  assign match_a = tick_q && running && (count_q == cmp_a_q);
  assign match_b = tick_q && running && (count_q == cmp_b_q);
  assign ovf     = tick_q && running && (count_q == TMO_COUNT_MAX);

  // Input a captures into b, input b captures into a.
  assign cap_into_b = cap_b_mode && edge_a;
  assign cap_into_a = cap_a_mode && edge_b;
  assign ev_a = cap_a_mode ? cap_into_a : match_a;
  assign ev_b = cap_b_mode ? cap_into_b : match_b;

  assign tog_match_a = !cap_a_mode && match_a && out_ctl_q[TMO_OC_TOG_A];
  assign tog_match_b = !cap_b_mode && match_b && out_ctl_q[TMO_OC_TOG_B];
  assign tog_edge    = edge_a && mode_ctl_q[TMO_MODE_EDGE_TOG];

  // One-shot is unavailable on the shared routing for channels 2 and 3.
  assign os_allowed = !route_shr || OS_SHR_OK;
  assign os_start = out_ctl_q[TMO_OC_OS_EN] && os_allowed
                    && (mode == TMO_FREE_RUN || mode == TMO_CLR_EDGE_A)
                    && ((wr_outctl && i_wdata[TMO_OC_OS_TRIG])
                        || edge_a);

  // The divider never restarts, so the first tick after a start falls
  // anywhere within one count period.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ps_q   <= '0;
      tick_q <= 1'b0;
    end else begin
      ps_q   <= (ps_q == PS_LAST) ? '0 : ps_q + 1'b1;
      tick_q <= (ps_q == PS_LAST);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_a_q <= 3'b000;
      sync_b_q <= 3'b000;
    end else begin
      sync_a_q <= {sync_a_q[1:0], i_capture_in_a_pin};
      sync_b_q <= {sync_b_q[1:0], i_capture_in_b_pin};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (!running) begin
      count_q <= '0;
    end else if (mode == TMO_CLR_EDGE_A && edge_a) begin
      count_q <= '0;
    end else if (mode == TMO_CLR_MATCH_A && match_a) begin
      count_q <= '0;
    end else if (tick_q) begin
      count_q <= count_q + 1'b1;
    end
  end

  // A capture wins over a software write in the same cycle; a read in
  // that cycle still returns the old value.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cmp_a_q <= TMO_CMP_RST;
      cmp_b_q <= TMO_CMP_RST;
    end else begin
      if (cap_into_a) begin
        cmp_a_q <= count_q;
      end else if (i_wr && i_addr == TMO_OFS_CMP_A) begin
        cmp_a_q <= i_wdata;
      end
      if (cap_into_b) begin
        cmp_b_q <= count_q;
      end else if (i_wr && i_addr == TMO_OFS_CMP_B) begin
        cmp_b_q <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_ctl_q <= TMO_MODE_RST;
      out_ctl_q  <= TMO_OUTCTL_RST;
    end else begin
      if (wr_mode) begin
        mode_ctl_q <= i_wdata[5:0];
      end
      if (wr_outctl) begin
        out_ctl_q <= i_wdata[7:0] & ~(8'h01 << TMO_OC_OS_TRIG);
      end
    end
  end

  // Output level: presets act only while stopped, matches and edges only
  // while running; two inversions in one cycle cancel.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      out_q <= 1'b0;
    end else if (!running) begin
      if (wr_outctl && !running) begin
        case (i_wdata[TMO_OC_PRE_HIGH:TMO_OC_PRE_LOW])
          2'b01:   out_q <= 1'b0;
          2'b10:   out_q <= 1'b1;
          default: out_q <= out_q;
        endcase
      end
    end else if (os_active_q) begin
      if (match_a) begin
        out_q <= 1'b0;
      end else if (match_b) begin
        out_q <= 1'b1;
      end
    end else begin
      out_q <= out_q ^ tog_match_a ^ tog_match_b ^ tog_edge;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      os_active_q <= 1'b0;
    end else if (!running || match_a) begin
      os_active_q <= 1'b0;
    end else if (os_start) begin
      os_active_q <= 1'b1;
    end
  end

  // Status bits are set by events and cleared by writing ones; a set in
  // the clearing cycle survives.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_st_q  <= TMO_IRQ_RST;
      irq_msk_q <= TMO_IRQ_RST;
    end else begin
      if (i_wr && i_addr == TMO_OFS_IRQST) begin
        irq_st_q <= (irq_st_q & ~i_wdata[TMO_IRQ_W-1:0])
                    | {ovf, ev_b, ev_a};
      end else begin
        irq_st_q <= irq_st_q | {ovf, ev_b, ev_a};
      end
      if (i_wr && i_addr == TMO_OFS_IRQMSK) begin
        irq_msk_q <= i_wdata[TMO_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_st_q & irq_msk_q);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer_out_ded_oe <= 1'b0;
      o_timer_out_shr_oe <= 1'b0;
    end else begin
      o_timer_out_ded_oe <= out_ctl_q[TMO_OC_ENABLE] && !route_shr;
      o_timer_out_shr_oe <= out_ctl_q[TMO_OC_ENABLE] && route_shr;
    end
  end

  assign o_timer_out_pin = out_q;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        TMO_OFS_COUNT:  o_rdata <= count_q;
        TMO_OFS_CMP_A:  o_rdata <= cmp_a_q;
        TMO_OFS_CMP_B:  o_rdata <= cmp_b_q;
        TMO_OFS_MODE:   o_rdata <= {10'h000, mode_ctl_q};
        TMO_OFS_OUTCTL: o_rdata <= {8'h00, out_ctl_q};
        TMO_OFS_IRQST:  o_rdata <= {13'h0000, irq_st_q};
        TMO_OFS_IRQMSK: o_rdata <= {13'h0000, irq_msk_q};
        default:        o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  a_preset_high: assert property (
    (!running && wr_outctl && i_wdata[3:2] == 2'b10) |=> out_q)
    else $error("Preset high did not drive the output high.");

  a_preset_low: assert property (
    (!running && wr_outctl && i_wdata[3:2] == 2'b01) |=> !out_q)
    else $error("Preset low did not drive the output low.");

  a_preset_hold: assert property (
    (!running && !(wr_outctl && i_wdata[3] != i_wdata[2]))
    |=> $stable(out_q))
    else $error("Output moved while stopped without a preset.");

  a_start_level: assert property (
    (!running && !wr_outctl ##1 running) |-> $stable(out_q))
    else $error("Output level changed at the start of counting.");

  a_match_b_toggle: assert property (
    (match_b && !cap_b_mode && out_ctl_q[4] && !os_active_q
     && !tog_match_a && !tog_edge) |=> (out_q != $past(out_q)))
    else $error("Match b did not invert the output.");

  a_match_b_hold: assert property (
    (match_b && !out_ctl_q[4] && !os_active_q
     && !tog_match_a && !tog_edge) |=> $stable(out_q))
    else $error("Match b changed the output with toggle off.");

  a_match_a_toggle: assert property (
    (match_a && !cap_a_mode && out_ctl_q[1] && !os_active_q
     && !tog_match_b && !tog_edge) |=> (out_q != $past(out_q)))
    else $error("Match a did not invert the output.");

  a_stop_clears: assert property (
    (mode == TMO_STOP) |=> (count_q == 16'h0000))
    else $error("Counter not cleared while stopped.");

  a_first_tick: assert property (
    (!running ##1 running) |-> ##[0:PRESCALE] tick_q)
    else $error("No count tick within one count period of start.");

  a_capture_irq: assert property (
    cap_into_b |=> (irq_st_q[1] && cmp_b_q == $past(count_q)))
    else $error("Capture into b lost its value or its flag.");

  a_shared_route: assert property (
    route_shr |-> (!edge_a ##1 !o_timer_out_ded_oe))
    else $error("Input a acted while the output used the shared pin.");

  a_os_route: assert property (
    (route_shr && CHANNEL >= 2) |=> !$rose(os_active_q))
    else $error("One-shot started on a forbidden routing.");

  // While armed, match b raises the output and match a ends the pulse.
  a_os_pulse_high: assert property (
    (os_active_q && match_b && !match_a) |=> out_q)
    else $error("One-shot did not drive the output high on match b.");

  a_os_pulse_end: assert property (
    (os_active_q && match_a) |=> (!out_q && !os_active_q))
    else $error("One-shot did not end on match a.");

  a_capture_a_irq: assert property (
    cap_into_a |=> (irq_st_q[0] && cmp_a_q == $past(count_q)))
    else $error("Capture into a lost its value or its flag.");

  c_running: cover property (!running ##1 running);
  c_match_b_tog: cover property (match_b && out_ctl_q[4]);
  c_capture: cover property (cap_into_b ##1 i_rd);
  c_preset_high: cover property (!running && wr_outctl && i_wdata[3:2] == 2'b10);
  c_oneshot: cover property ($rose(os_active_q));

endmodule : tmo_timer16

// *** tb/tmo_pin_model.sv ***
// Far-side model: drives the two capture input pins of the timer channel.
// Assumes one-cycle fire requests from the bench on the system clock.
`timescale 1ns/1ps
module tmo_pin_model (
  input  wire logic i_sys_clk,
  input  wire logic i_fire_a,
  input  wire logic i_fire_b,
  output logic      o_capture_in_a_pin,
  output logic      o_capture_in_b_pin
);
  logic [2:0] a_q = 3'h0;
  logic [2:0] b_q = 3'h0;

  // Pulses stay high four clocks so the input synchroniser sees them.
  always_ff @(posedge i_sys_clk) begin
    a_q <= i_fire_a ? 3'h4 : ((a_q != 3'h0) ? a_q - 3'h1 : 3'h0);
    b_q <= i_fire_b ? 3'h4 : ((b_q != 3'h0) ? b_q - 3'h1 : 3'h0);
  end

  assign o_capture_in_a_pin = (a_q != 3'h0);
  assign o_capture_in_b_pin = (b_q != 3'h0);
endmodule : tmo_pin_model

// *** tb/tb.sv ***
// Self-checking bench for the timer output level channel.
// Assumes the pin model drives the capture inputs; PRESCALE and CHANNEL
// are both set to 2, so the shared routing refuses one-shot pulses.
`timescale 1ns/1ps
module tb;
  import tmo_pkg::*;
  logic              i_sys_clk = 1'b0;
  logic              i_rst     = 1'b1;
  logic [TMO_AW-1:0] i_addr    = '0;
  logic [TMO_DW-1:0] i_wdata   = '0;
  logic              i_wr      = 1'b0;
  logic              i_rd      = 1'b0;
  logic              fire_a    = 1'b0;
  logic              fire_b    = 1'b0;
  logic [TMO_DW-1:0] o_rdata;
  logic              cap_a;
  logic              cap_b;
  logic              out_pin;
  logic              ded_oe;
  logic              shr_oe;
  logic              o_irq;
  logic [15:0]       d;
  int                fail_count = 0;
  int                checked    = 0;
  int                seed       = 32'h5524_c1b0;
  int                n;

  always #25 i_sys_clk = ~i_sys_clk;

  tmo_timer16 #(.PRESCALE(2), .CHANNEL(2)) i_tmo_timer16 (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_capture_in_a_pin(cap_a), .i_capture_in_b_pin(cap_b),
    .o_timer_out_pin(out_pin), .o_timer_out_ded_oe(ded_oe),
    .o_timer_out_shr_oe(shr_oe), .o_irq(o_irq));

  tmo_pin_model i_tmo_pin_model (
    .i_sys_clk(i_sys_clk), .i_fire_a(fire_a), .i_fire_b(fire_b),
    .o_capture_in_a_pin(cap_a), .o_capture_in_b_pin(cap_b));

  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic fire(input logic sel);
    @(posedge i_sys_clk);
    fire_a <= ~sel;
    fire_b <= sel;
    @(posedge i_sys_clk);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
  endtask : fire

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e,
                          input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_word

  task automatic chk_bit(input logic g, input logic e, input string m);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: %s got %b exp %b", $time, m, g, e);
    end
  endtask : chk_bit

  // Safe compare-b rewrite while counting; tog picks the toggle re-enable.
  task automatic rewrite_b(input logic [15:0] v, input logic tog);
    wr(TMO_OFS_IRQMSK, 16'h0000);
    wr(TMO_OFS_OUTCTL, 16'h0000);
    wr(TMO_OFS_CMP_B, v);
    cyc(2);
    wr(TMO_OFS_OUTCTL, {11'h000, tog, 4'h0});
    wr(TMO_OFS_IRQST, 16'h0002);
    wr(TMO_OFS_IRQMSK, 16'h0002);
  endtask : rewrite_b

  function automatic logic lvl_after(input logic cur, input logic [1:0] c);
    return (c == 2'b10) ? 1'b1 : ((c == 2'b01) ? 1'b0 : cur);
  endfunction : lvl_after

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    #1_000_000;
    fail_count++;
    end_of_test();
  end

  initial begin
    logic       lvl;
    logic [1:0] c;
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk_bit(out_pin, 1'b0, "reset level");
    for (int k = 0; k < 8; k++) begin
      rd(8'(k * 4));
      chk_word(d, 16'h0000, "reset register");
    end
    $display("test reset finished");
    wr(TMO_OFS_OUTCTL, 16'h0008);
    cyc(2);
    chk_bit(out_pin, 1'b1, "preset high");
    wr(TMO_OFS_OUTCTL, 16'h0000);
    cyc(2);
    chk_bit(out_pin, 1'b1, "preset back to keep");
    lvl = 1'b1;
    for (int k = 0; k < 16; k++) begin
      c = 2'($unsigned($random(seed)) % 3);
      wr(TMO_OFS_OUTCTL, {12'h000, c, 2'b00});
      lvl = lvl_after(lvl, c);
      cyc(2);
      chk_bit(out_pin, lvl, "random preset");
    end
    $display("test preset finished");
    wr(TMO_OFS_CMP_A, 16'h0003);
    wr(TMO_OFS_CMP_B, 16'h0005);
    for (int m = 1; m < 4; m++) begin
      wr(TMO_OFS_MODE, 16'h0000);
      wr(TMO_OFS_OUTCTL, 16'h0008);
      wr(TMO_OFS_OUTCTL, 16'h0000);
      wr(TMO_OFS_MODE, 16'(m << 2));
      cyc(10);
      chk_bit(out_pin, 1'b1, "level at start");
    end
    wr(TMO_OFS_MODE, 16'h0000);
    cyc(2);
    rd(TMO_OFS_COUNT);
    chk_word(d, 16'h0000, "stopped count");
    $display("test start finished");
    wr(TMO_OFS_OUTCTL, 16'h0004);
    wr(TMO_OFS_CMP_B, 16'h0003);
    wr(TMO_OFS_OUTCTL, 16'h0010);
    wr(TMO_OFS_IRQMSK, 16'h0002);
    wr(TMO_OFS_MODE, 16'h0004);
    cyc(20);
    chk_bit(out_pin, 1'b1, "match b toggle");
    rd(TMO_OFS_COUNT);
    rewrite_b(d + 16'h0014, 1'b0);
    cyc(60);
    chk_bit(out_pin, 1'b1, "toggle disabled");
    chk_bit(o_irq, 1'b1, "match b event");
    rd(TMO_OFS_COUNT);
    rewrite_b(d + 16'h0014, 1'b1);
    cyc(60);
    chk_bit(out_pin, 1'b0, "toggle after rewrite");
    $display("test match b finished");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_CMP_B, 16'h0002);
    wr(TMO_OFS_IRQST, 16'h0007);
    wr(TMO_OFS_MODE, 16'h0004);
    n = 0;
    while (o_irq !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk_bit(n >= 3 && n <= 12, 1'b1, "first match delay");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_OUTCTL, 16'h0004);
    wr(TMO_OFS_OUTCTL, 16'h0002);
    wr(TMO_OFS_MODE, 16'h000C);
    cyc(4);
    n = 0;
    lvl = out_pin;
    repeat (64) begin
      cyc(1);
      if (out_pin !== lvl)
        n++;
      lvl = out_pin;
    end
    chk_bit(n >= 6 && n <= 11, 1'b1, "match a toggles");
    $display("test match a finished");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_CMP_A, 16'hFF00);
    wr(TMO_OFS_CMP_B, 16'hFF00);
    wr(TMO_OFS_OUTCTL, 16'h0001);
    wr(TMO_OFS_IRQST, 16'h0007);
    wr(TMO_OFS_IRQMSK, 16'h0000);
    cyc(1);
    chk_bit(ded_oe, 1'b1, "dedicated drive");
    chk_bit(shr_oe, 1'b0, "shared idle");
    wr(TMO_OFS_MODE, 16'h0034);
    fire(1'b0);
    repeat (5) rd(TMO_OFS_CMP_B);
    chk_bit(o_irq, 1'b0, "masked capture");
    wr(TMO_OFS_IRQMSK, 16'h0003);
    cyc(2);
    chk_bit(o_irq, 1'b1, "capture irq");
    rd(TMO_OFS_IRQST);
    chk_word(d, 16'h0002, "capture status");
    rd(TMO_OFS_CMP_B);
    chk_bit(d != 16'h0000, 1'b1, "captured count");
    wr(TMO_OFS_IRQST, 16'h0002);
    cyc(2);
    chk_bit(o_irq, 1'b0, "irq cleared");
    fire(1'b1);
    cyc(8);
    rd(TMO_OFS_IRQST);
    chk_word(d, 16'h0001, "capture b status");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_OUTCTL, 16'h0081);
    wr(TMO_OFS_IRQST, 16'h0007);
    cyc(1);
    chk_bit(shr_oe, 1'b1, "shared drive");
    chk_bit(ded_oe, 1'b0, "dedicated idle");
    wr(TMO_OFS_MODE, 16'h0024);
    fire(1'b0);
    cyc(8);
    rd(TMO_OFS_IRQST);
    chk_word(d, 16'h0000, "input a blocked");
    $display("test capture finished");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_OUTCTL, 16'h0005);
    wr(TMO_OFS_MODE, 16'h000A);
    cyc(30);
    fire(1'b0);
    cyc(4);
    chk_bit(out_pin, 1'b1, "edge inversion");
    rd(TMO_OFS_COUNT);
    chk_bit(d < 16'h0004, 1'b1, "clear on edge a");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_CMP_A, 16'h0008);
    wr(TMO_OFS_CMP_B, 16'h0004);
    wr(TMO_OFS_OUTCTL, 16'h0025);
    wr(TMO_OFS_MODE, 16'h0004);
    wr(TMO_OFS_OUTCTL, 16'h0061);
    cyc(10);
    chk_bit(out_pin, 1'b1, "one-shot rise");
    cyc(10);
    chk_bit(out_pin, 1'b0, "one-shot end");
    wr(TMO_OFS_MODE, 16'h0000);
    wr(TMO_OFS_OUTCTL, 16'h00A5);
    wr(TMO_OFS_MODE, 16'h0004);
    wr(TMO_OFS_OUTCTL, 16'h00E1);
    cyc(10);
    chk_bit(out_pin, 1'b0, "no one-shot on shared pin");
    $display("test one-shot finished");
    end_of_test();
  end
endmodule : tb
